// ---- src/telem_pkg.sv ----
`default_nettype none
package telem_pkg;

   // ----------------------------------------------------------------
   // command codes
   // ----------------------------------------------------------------
   localparam logic [7:0] CODE_VIN = 8'h88;
   localparam logic [7:0] CODE_VOUT = 8'h8b;
   localparam logic [7:0] CODE_IOUT = 8'h8c;
   localparam logic [7:0] CODE_TEXT = 8'h8d;
   localparam logic [7:0] CODE_TDIE = 8'h8e;
   localparam logic [7:0] CODE_POUT = 8'h96;
   localparam logic [7:0] CODE_FINE_IOUT = 8'hbb;
   localparam logic [7:0] CODE_IOUT_PEAK = 8'hd7;
   localparam logic [7:0] CODE_IOUT_MIN = 8'hd8;
   localparam logic [7:0] CODE_VOUT_PEAK = 8'hdd;
   localparam logic [7:0] CODE_VIN_PEAK = 8'hde;
   localparam logic [7:0] CODE_TEXT_PEAK = 8'hdf;
   localparam logic [7:0] CODE_SENSE = 8'hfa;
   localparam logic [7:0] CODE_VOUT_MIN = 8'hfb;
   localparam logic [7:0] CODE_VIN_MIN = 8'hfc;
   localparam logic [7:0] CODE_TEXT_MIN = 8'hfd;
   localparam logic [7:0] CODE_COMMON = 8'hef;

   // ----------------------------------------------------------------
   // tracker reset values
   // ----------------------------------------------------------------
   localparam logic [15:0] L11_PEAK_RST = 16'h7c00;
   localparam logic [15:0] L11_MIN_RST = 16'h7bff;
   localparam logic [15:0] VOUT_PEAK_RST = 16'hf800;
   localparam logic [15:0] VOUT_MIN_RST = 16'hffff;

   // ----------------------------------------------------------------
   // status byte layout
   // ----------------------------------------------------------------
   localparam int ST_ALERT_BIT = 7;
   localparam int ST_READY_BIT = 6;
   localparam int ST_SHARE_BIT = 1;
   localparam int ST_WP_BIT = 0;
   localparam logic [3:0] ST_RESERVED_ONES = 4'hf;

   // ----------------------------------------------------------------
   // fine current format
   // ----------------------------------------------------------------
   // one count is 2.5 mA, so amperes times 400 gives counts
   localparam logic [63:0] FINE_PER_AMP = 64'h0000_0000_0000_0190;
   localparam logic [15:0] FINE_MAX = 16'h7fff;
   localparam logic [15:0] FINE_MIN = 16'h8000;
   localparam int L11_FRAC = 16;

   // ----------------------------------------------------------------
   // timing
   // ----------------------------------------------------------------
   localparam int CLK_PERIOD_NS = 10;
   localparam int SHARE_LOW_TIME_NS = 2000;
   localparam int SHARE_LOW_CYCLES = (SHARE_LOW_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int SHARE_CNT_W = 10;

   typedef enum logic [2:0] {
      Q_VIN, Q_VOUT, Q_IOUT, Q_TEXT, Q_TDIE, Q_POUT
   } quantity_t;

endpackage
`default_nettype wire

// ---- src/telemetry_readback_bank.sv ----
`timescale 1ns/1ps
`default_nettype none

module telemetry_readback_bank (
   input wire logic sys_clk,
   input wire logic arst_n,
   // host command port
   input wire logic cmd_valid,
   input wire logic [7:0] cmd_code,
   input wire logic [1:0] page,
   output logic rd_valid,
   output logic [15:0] rd_data,
   output logic cmd_nack,
   output logic busy_flag_set,
   // device state
   input wire logic busy,
   input wire logic alert_clear,
   input wire logic alert_other,
   input wire logic clear_faults,
   input wire logic [1:0] clear_page,
   input wire logic [3:0] chan_on,
   // conversions
   input wire logic conv_valid,
   input wire telem_pkg::quantity_t conv_kind,
   input wire logic [1:0] conv_chan,
   input wire logic [15:0] conv_data,
   input wire logic [15:0] conv_sense,
   input wire logic conv_temp_ok,
   // pins
   input wire logic alert_in,
   output logic alert_out,
   output logic alert_oe,
   input wire logic share_clk_in,
   input wire logic wp_in
);

   // ----------------------------------------------------------------
   // helpers
   // ----------------------------------------------------------------
   // L11 scaled by 2^16 so any two codes compare as plain signed numbers
   function automatic logic signed [63:0] l11_val(input logic [15:0] w);
      logic signed [63:0] m;
      logic [5:0] sh;
      m = 64'(signed'(w[10:0]));
      sh = 6'(signed'(w[15:11])) + 6'h10;
      return m <<< sh;
   endfunction

   // ----------------------------------------------------------------
   // pin synchronisers
   // ----------------------------------------------------------------
   logic alert_s1, alert_s2, share_s1, share_s2, share_s3, wp_s1, wp_s2;

   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         alert_s1 <= 1'b1;
         alert_s2 <= 1'b1;
         share_s1 <= 1'b1;
         share_s2 <= 1'b1;
         share_s3 <= 1'b1;
         wp_s1 <= 1'b0;
         wp_s2 <= 1'b0;
      end else begin
         alert_s1 <= alert_in;
         alert_s2 <= alert_s1;
         share_s1 <= share_clk_in;
         share_s2 <= share_s1;
         share_s3 <= share_s2;
         wp_s1 <= wp_in;
         wp_s2 <= wp_s1;
      end
   end

   // share clock counts as held low once it stays low with no edge for a while
   logic [telem_pkg::SHARE_CNT_W-1:0] share_low_cnt;
   logic share_held_low;
   wire share_edge = share_s2 ^ share_s3;
   wire share_low_full = share_low_cnt == telem_pkg::SHARE_CNT_W'(telem_pkg::SHARE_LOW_CYCLES);

   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         share_low_cnt <= '0;
         share_held_low <= 1'b0;
      end else begin
         if (share_edge || share_s2) begin
            share_low_cnt <= '0;
         end else if (!share_low_full) begin
            share_low_cnt <= share_low_cnt + 1'b1;
         end
         share_held_low <= share_low_full && !share_s2 && !share_edge;
      end
   end

   // ----------------------------------------------------------------
   // command decode
   // ----------------------------------------------------------------
   wire is_common = cmd_code == telem_pkg::CODE_COMMON;
   wire is_known = is_common ||
      cmd_code == telem_pkg::CODE_VIN || cmd_code == telem_pkg::CODE_VOUT ||
      cmd_code == telem_pkg::CODE_IOUT || cmd_code == telem_pkg::CODE_TEXT ||
      cmd_code == telem_pkg::CODE_TDIE || cmd_code == telem_pkg::CODE_POUT ||
      cmd_code == telem_pkg::CODE_FINE_IOUT || cmd_code == telem_pkg::CODE_IOUT_PEAK ||
      cmd_code == telem_pkg::CODE_IOUT_MIN || cmd_code == telem_pkg::CODE_VOUT_PEAK ||
      cmd_code == telem_pkg::CODE_VIN_PEAK || cmd_code == telem_pkg::CODE_TEXT_PEAK ||
      cmd_code == telem_pkg::CODE_SENSE || cmd_code == telem_pkg::CODE_VOUT_MIN ||
      cmd_code == telem_pkg::CODE_VIN_MIN || cmd_code == telem_pkg::CODE_TEXT_MIN;
   // the status byte is the one command a busy device still serves
   wire accept = cmd_valid && is_known && (!busy || is_common);
   wire refuse_busy = cmd_valid && busy && !is_common;
   wire refuse = cmd_valid && !accept;

   // ----------------------------------------------------------------
   // alert line
   // ----------------------------------------------------------------
   logic refused_alert;

   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         refused_alert <= 1'b0;
      end else if (refuse_busy) begin
         refused_alert <= 1'b1;
      end else if (alert_clear) begin
         refused_alert <= 1'b0;
      end
   end

   assign alert_out = 1'b0;
   assign alert_oe = refused_alert || alert_other;

   // ----------------------------------------------------------------
   // telemetry storage
   // ----------------------------------------------------------------
   logic [15:0] input_voltage_reading, die_temp_reading;
   logic [15:0] input_voltage_peak_tracker, input_voltage_min_tracker;
   logic [15:0] output_voltage_reading [4];
   logic [15:0] output_current_reading [4];
   logic [15:0] external_temp_reading [4];
   logic [15:0] output_power_reading [4];
   logic [15:0] fine_current_reading [4];
   logic [15:0] sense_resistor_voltage [4];
   logic [15:0] output_voltage_peak_tracker [4];
   logic [15:0] output_voltage_min_tracker [4];
   logic [15:0] current_peak_tracker [4];
   logic [15:0] current_min_tracker [4];
   logic [15:0] external_temp_peak_tracker [4];
   logic [15:0] external_temp_min_tracker [4];
   logic [3:0] chan_on_q;

   wire [3:0] chan_rise = chan_on & ~chan_on_q;
   wire vin_clear = clear_faults || |chan_rise;
   wire [3:0] page_hit = 4'h1 << clear_page;
   wire [3:0] chan_clear = ({4{clear_faults}} & page_hit) | chan_rise;
   wire [3:0] conv_hit = {4{conv_valid}} & (4'h1 << conv_chan);

   // invalid external sensing falls back on the die reading
   wire [15:0] text_word = conv_temp_ok ? conv_data : die_temp_reading;
   wire signed [63:0] conv_l11 = l11_val(conv_data);
   wire signed [63:0] text_l11 = l11_val(text_word);

   // fine current: amperes times 400, floored, then clamped
   wire signed [63:0] fine_wide = (conv_l11 * signed'(telem_pkg::FINE_PER_AMP)) >>> telem_pkg::L11_FRAC;
   wire fine_over = fine_wide > 64'sd32767;
   wire fine_under = fine_wide < -64'sd32768;
   wire [15:0] fine_word = fine_over ? telem_pkg::FINE_MAX :
      fine_under ? telem_pkg::FINE_MIN : fine_wide[15:0];
   wire [15:0] sense_abs = conv_sense[15] ? 16'(-conv_sense) : conv_sense;

   wire vin_conv = conv_valid && conv_kind == telem_pkg::Q_VIN;

   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         chan_on_q <= '0;
         input_voltage_reading <= '0;
         die_temp_reading <= '0;
         input_voltage_peak_tracker <= telem_pkg::L11_PEAK_RST;
         input_voltage_min_tracker <= telem_pkg::L11_MIN_RST;
      end else begin
         chan_on_q <= chan_on;
         if (vin_conv) begin
            input_voltage_reading <= conv_data;
         end
         // die temperature only refreshes its own reading
         if (conv_valid && conv_kind == telem_pkg::Q_TDIE) begin
            die_temp_reading <= conv_data;
         end
         if (vin_clear) begin
            input_voltage_peak_tracker <= telem_pkg::L11_PEAK_RST;
            input_voltage_min_tracker <= telem_pkg::L11_MIN_RST;
         end else if (vin_conv) begin
            if (conv_l11 > l11_val(input_voltage_peak_tracker)) begin
               input_voltage_peak_tracker <= conv_data;
            end
            if (conv_l11 < l11_val(input_voltage_min_tracker)) begin
               input_voltage_min_tracker <= conv_data;
            end
         end
      end
   end

   // per channel: a reset event wins over a conversion in the same cycle
   for (genvar ch = 0; ch < 4; ch++) begin : g_chan
      wire hit = conv_hit[ch];
      // the peak reset mark stands for 0.0, not for its unsigned code
      logic vout_peak_seen;
      wire vout_peak_up = !vout_peak_seen || conv_data > output_voltage_peak_tracker[ch];
      always_ff @(posedge sys_clk or negedge arst_n) begin
         if (!arst_n) begin
            output_voltage_reading[ch] <= '0;
            output_current_reading[ch] <= '0;
            external_temp_reading[ch] <= '0;
            output_power_reading[ch] <= '0;
            fine_current_reading[ch] <= '0;
            sense_resistor_voltage[ch] <= '0;
            vout_peak_seen <= 1'b0;
            output_voltage_peak_tracker[ch] <= telem_pkg::VOUT_PEAK_RST;
            output_voltage_min_tracker[ch] <= telem_pkg::VOUT_MIN_RST;
            current_peak_tracker[ch] <= telem_pkg::L11_PEAK_RST;
            current_min_tracker[ch] <= telem_pkg::L11_MIN_RST;
            external_temp_peak_tracker[ch] <= telem_pkg::L11_PEAK_RST;
            external_temp_min_tracker[ch] <= telem_pkg::L11_MIN_RST;
         end else begin
            if (hit && conv_kind == telem_pkg::Q_VOUT) begin
               output_voltage_reading[ch] <= conv_data;
            end
            if (hit && conv_kind == telem_pkg::Q_IOUT) begin
               output_current_reading[ch] <= conv_data;
               fine_current_reading[ch] <= fine_word;
               sense_resistor_voltage[ch] <= sense_abs;
            end
            if (hit && conv_kind == telem_pkg::Q_TEXT) begin
               external_temp_reading[ch] <= text_word;
            end
            if (hit && conv_kind == telem_pkg::Q_POUT) begin
               output_power_reading[ch] <= conv_data;
            end
            if (chan_clear[ch]) begin
               vout_peak_seen <= 1'b0;
               output_voltage_peak_tracker[ch] <= telem_pkg::VOUT_PEAK_RST;
               output_voltage_min_tracker[ch] <= telem_pkg::VOUT_MIN_RST;
               current_peak_tracker[ch] <= telem_pkg::L11_PEAK_RST;
               current_min_tracker[ch] <= telem_pkg::L11_MIN_RST;
               external_temp_peak_tracker[ch] <= telem_pkg::L11_PEAK_RST;
               external_temp_min_tracker[ch] <= telem_pkg::L11_MIN_RST;
            end else if (hit) begin
               // output voltage words are unsigned; the first reading always seeds the peak
               if (conv_kind == telem_pkg::Q_VOUT) begin
                  vout_peak_seen <= 1'b1;
                  if (vout_peak_up) begin
                     output_voltage_peak_tracker[ch] <= conv_data;
                  end
                  if (conv_data < output_voltage_min_tracker[ch]) begin
                     output_voltage_min_tracker[ch] <= conv_data;
                  end
               end
               if (conv_kind == telem_pkg::Q_IOUT) begin
                  if (conv_l11 > l11_val(current_peak_tracker[ch])) begin
                     current_peak_tracker[ch] <= conv_data;
                  end
                  if (conv_l11 < l11_val(current_min_tracker[ch])) begin
                     current_min_tracker[ch] <= conv_data;
                  end
               end
               if (conv_kind == telem_pkg::Q_TEXT) begin
                  if (text_l11 > l11_val(external_temp_peak_tracker[ch])) begin
                     external_temp_peak_tracker[ch] <= text_word;
                  end
                  if (text_l11 < l11_val(external_temp_min_tracker[ch])) begin
                     external_temp_min_tracker[ch] <= text_word;
                  end
               end
            end
         end
      end
   end

   // ----------------------------------------------------------------
   // read path
   // ----------------------------------------------------------------
   wire [7:0] status_byte = {alert_s2, !busy, telem_pkg::ST_RESERVED_ONES,
      share_held_low, wp_s2};
   logic [15:0] read_word;

   always_comb begin
      read_word = 16'h0000;
      unique case (cmd_code)
         telem_pkg::CODE_COMMON: read_word = {8'h00, status_byte};
         telem_pkg::CODE_VIN: read_word = input_voltage_reading;
         telem_pkg::CODE_VOUT: read_word = output_voltage_reading[page];
         telem_pkg::CODE_IOUT: read_word = output_current_reading[page];
         telem_pkg::CODE_TEXT: read_word = external_temp_reading[page];
         telem_pkg::CODE_TDIE: read_word = die_temp_reading;
         telem_pkg::CODE_POUT: read_word = output_power_reading[page];
         telem_pkg::CODE_FINE_IOUT: read_word = fine_current_reading[page];
         telem_pkg::CODE_SENSE: read_word = sense_resistor_voltage[page];
         telem_pkg::CODE_VIN_PEAK: read_word = input_voltage_peak_tracker;
         telem_pkg::CODE_VOUT_PEAK: read_word = output_voltage_peak_tracker[page];
         telem_pkg::CODE_IOUT_PEAK: read_word = current_peak_tracker[page];
         telem_pkg::CODE_TEXT_PEAK: read_word = external_temp_peak_tracker[page];
         telem_pkg::CODE_VIN_MIN: read_word = input_voltage_min_tracker;
         telem_pkg::CODE_VOUT_MIN: read_word = output_voltage_min_tracker[page];
         telem_pkg::CODE_IOUT_MIN: read_word = current_min_tracker[page];
         telem_pkg::CODE_TEXT_MIN: read_word = external_temp_min_tracker[page];
         default: read_word = 16'h0000;
      endcase
   end

   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         rd_valid <= 1'b0;
         rd_data <= '0;
         cmd_nack <= 1'b0;
         busy_flag_set <= 1'b0;
      end else begin
         rd_valid <= accept;
         if (accept) begin
            rd_data <= read_word;
         end
         cmd_nack <= refuse;
         busy_flag_set <= refuse_busy;
      end
   end

   // ----------------------------------------------------------------
   // assertions
   // ----------------------------------------------------------------
   sequence busy_poll_s;
      cmd_valid && busy && is_common;
   endsequence

   sequence busy_other_s;
      cmd_valid && busy && !is_common;
   endsequence

   common_while_busy_a: assert property (
      @(posedge sys_clk) disable iff (!arst_n)
      busy_poll_s |=> rd_valid && !cmd_nack && rd_data[15:8] == 8'h00)
      else $error("status byte not served while busy");

   busy_refuse_a: assert property (
      @(posedge sys_clk) disable iff (!arst_n)
      busy_other_s |=> cmd_nack && busy_flag_set && !rd_valid)
      else $error("busy command not refused");

   refuse_alert_a: assert property (
      @(posedge sys_clk) disable iff (!arst_n)
      busy_flag_set |-> alert_oe && !alert_out)
      else $error("alert not driven after busy refusal");

   status_layout_a: assert property (
      @(posedge sys_clk) disable iff (!arst_n)
      cmd_valid && is_common |=> rd_data[5:2] == 4'hf && rd_data[6] == !$past(busy)
         && rd_data[7] == $past(alert_s2))
      else $error("status byte layout wrong");

   vin_reset_a: assert property (
      @(posedge sys_clk) disable iff (!arst_n)
      vin_clear |=> input_voltage_peak_tracker == 16'h7c00 && input_voltage_min_tracker == 16'h7bff)
      else $error("input trackers not reset");

   vout_min_reset_a: assert property (
      @(posedge sys_clk) disable iff (!arst_n)
      clear_faults && clear_page == 2'h3 |=> output_voltage_min_tracker[3] == 16'hffff
         && output_voltage_peak_tracker[3] == 16'hf800)
      else $error("channel trackers not reset");

   die_substitute_a: assert property (
      @(posedge sys_clk) disable iff (!arst_n)
      conv_valid && conv_kind == telem_pkg::Q_TEXT && !conv_temp_ok && conv_chan == 2'h3
         |=> external_temp_reading[3] == $past(die_temp_reading))
      else $error("die temperature not substituted");

   fine_saturate_a: assert property (
      @(posedge sys_clk) disable iff (!arst_n)
      conv_valid && conv_kind == telem_pkg::Q_IOUT && conv_chan == 2'h2 && fine_over
         |=> fine_current_reading[2] == 16'h7fff)
      else $error("fine current wrapped");

   sense_abs_a: assert property (
      @(posedge sys_clk) disable iff (!arst_n)
      conv_valid && conv_kind == telem_pkg::Q_IOUT && conv_chan == 2'h2 && conv_sense[15]
         |=> sense_resistor_voltage[2] == 16'(-$past(conv_sense)))
      else $error("sense voltage not absolute");

   vin_peak_grows_a: assert property (
      @(posedge sys_clk) disable iff (!arst_n)
      !vin_clear ##1 1'b1 |-> l11_val(input_voltage_peak_tracker)
         >= l11_val($past(input_voltage_peak_tracker)))
      else $error("input peak tracker fell");

endmodule

`default_nettype wire

// ---- tb/telem_host.sv ----
`timescale 1ns/1ps
`default_nettype none
module telem_host (
   input wire logic sys_clk,
   output logic cmd_valid,
   output logic [7:0] cmd_code,
   output logic [1:0] page,
   input wire logic rd_valid,
   input wire logic [15:0] rd_data,
   input wire logic cmd_nack
);
   initial begin
      cmd_valid = 1'b0;
      cmd_code = 8'h00;
      page = 2'h0;
   end
   // ----------------------------------------------------------------
   // one command per call
   // ----------------------------------------------------------------
   task automatic issue(input logic [7:0] c, input logic [1:0] p, output logic [15:0] d,
         output logic nk, output logic ok);
      int i;
      @(negedge sys_clk);
      cmd_valid = 1'b1;
      cmd_code = c;
      page = p;
      @(negedge sys_clk);
      cmd_valid = 1'b0;
      // inverted code so a late sampler cannot still see the real one
      cmd_code = ~c;
      page = ~p;
      ok = 1'b0;
      for (i = 0; i < 4 && !ok; i++) begin
         if (rd_valid === 1'b1 || cmd_nack === 1'b1) ok = 1'b1;
         else @(negedge sys_clk);
      end
      d = rd_data;
      nk = cmd_nack;
   endtask
endmodule
`default_nettype wire

// ---- tb/telemetry_readback_bank_tb_top.sv ----
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin miscompares++; $display("BAD %0t got %h exp %h", $time, (a), (b)); end end
module telemetry_readback_bank_tb_top;
   // ----------------------------------------------------------------
   // stimulus and wiring
   // ----------------------------------------------------------------
   logic sys_clk = 1'b0, arst_n = 1'b0, busy = 1'b0, alert_clear = 1'b0, alert_other = 1'b0;
   logic clear_faults = 1'b0, conv_valid = 1'b0, conv_temp_ok = 1'b1, wp_in = 1'b1;
   logic share_clk_in = 1'b0, share_run = 1'b1;
   logic [1:0] clear_page = 2'h0, conv_chan = 2'h0;
   logic [3:0] chan_on = 4'h0;
   logic [15:0] conv_data = 16'h0000, conv_sense = 16'h0000;
   telem_pkg::quantity_t conv_kind = telem_pkg::Q_VIN;
   wire cmd_valid, rd_valid, cmd_nack, busy_flag_set, alert_out, alert_oe, alert_in;
   wire [7:0] cmd_code;
   wire [1:0] page;
   wire [15:0] rd_data;
   int miscompares = 0, checks = 0;
   logic [7:0] rc [8] = '{8'hde, 8'hfc, 8'hdd, 8'hfb, 8'hd7, 8'hd8, 8'hdf, 8'hfd};
   logic [15:0] rv [8] = '{16'h7c00, 16'h7bff, 16'hf800, 16'hffff, 16'h7c00, 16'h7bff,
      16'h7c00, 16'h7bff};
   // open-drain alert line with a pull-up
   assign alert_in = !(alert_oe === 1'b1);
   always #5 sys_clk = ~sys_clk;
   always #80 share_clk_in = share_run ? ~share_clk_in : 1'b0;
   telemetry_readback_bank i_telemetry_readback_bank (.sys_clk, .arst_n, .cmd_valid, .cmd_code,
      .page, .rd_valid, .rd_data, .cmd_nack, .busy_flag_set, .busy, .alert_clear, .alert_other,
      .clear_faults, .clear_page, .chan_on, .conv_valid, .conv_kind, .conv_chan, .conv_data,
      .conv_sense, .conv_temp_ok, .alert_in, .alert_out, .alert_oe, .share_clk_in, .wp_in);
   telem_host i_telem_host (.sys_clk, .cmd_valid, .cmd_code, .page, .rd_valid, .rd_data,
      .cmd_nack);
   // ----------------------------------------------------------------
   // tasks
   // ----------------------------------------------------------------
   task automatic final_report();
      if (miscompares == 0 && checks > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask
   task automatic rd(input logic [7:0] c, input logic [1:0] p, input logic [15:0] e,
         input logic enk);
      logic [15:0] d;
      logic nk, ok;
      i_telem_host.issue(c, p, d, nk, ok);
      if (ok !== 1'b1) begin
         miscompares++;
         final_report();
      end
      `CHK(nk, enk)
      if (!enk) `CHK(d, e)
   endtask
   task automatic cv(input telem_pkg::quantity_t k, input logic [1:0] ch, input logic [15:0] d,
         input logic [15:0] s, input logic tok);
      @(negedge sys_clk);
      conv_valid = 1'b1;
      conv_kind = k;
      conv_chan = ch;
      conv_data = d;
      conv_sense = s;
      conv_temp_ok = tok;
      @(negedge sys_clk);
      conv_valid = 1'b0;
   endtask
   // ----------------------------------------------------------------
   // sequence
   // ----------------------------------------------------------------
   initial begin
      repeat (8) @(negedge sys_clk);
      arst_n = 1'b1;
      for (int i = 0; i < 8; i++) rd(rc[i], 2'h3, rv[i], 1'b0);
      cv(telem_pkg::Q_VIN, 2'h0, 16'h0064, 16'h0000, 1'b1);
      cv(telem_pkg::Q_VIN, 2'h0, 16'h0032, 16'h0000, 1'b1);
      rd(8'h88, 2'h0, 16'h0032, 1'b0);
      rd(8'hde, 2'h0, 16'h0064, 1'b0);
      rd(8'hfc, 2'h0, 16'h0032, 1'b0);
      cv(telem_pkg::Q_VOUT, 2'h1, 16'h1000, 16'h0000, 1'b1);
      cv(telem_pkg::Q_VOUT, 2'h1, 16'h0800, 16'h0000, 1'b1);
      rd(8'h8b, 2'h1, 16'h0800, 1'b0);
      rd(8'hdd, 2'h1, 16'h1000, 1'b0);
      rd(8'hfb, 2'h1, 16'h0800, 1'b0);
      rd(8'hdd, 2'h0, 16'hf800, 1'b0);
      cv(telem_pkg::Q_IOUT, 2'h2, 16'h000a, 16'hfe0c, 1'b1);
      rd(8'h8c, 2'h2, 16'h000a, 1'b0);
      rd(8'hbb, 2'h2, 16'h0fa0, 1'b0);
      rd(8'hfa, 2'h2, 16'h01f4, 1'b0);
      rd(8'hd7, 2'h2, 16'h000a, 1'b0);
      rd(8'hd8, 2'h2, 16'h000a, 1'b0);
      cv(telem_pkg::Q_IOUT, 2'h2, 16'h0064, 16'h0000, 1'b1);
      rd(8'hbb, 2'h2, 16'h7fff, 1'b0);
      cv(telem_pkg::Q_IOUT, 2'h2, 16'h079c, 16'h0000, 1'b1);
      rd(8'hbb, 2'h2, 16'h8000, 1'b0);
      cv(telem_pkg::Q_POUT, 2'h0, 16'h0005, 16'h0000, 1'b1);
      rd(8'h96, 2'h0, 16'h0005, 1'b0);
      cv(telem_pkg::Q_TEXT, 2'h3, 16'h0019, 16'h0000, 1'b1);
      cv(telem_pkg::Q_TDIE, 2'h0, 16'h001e, 16'h0000, 1'b1);
      rd(8'h8e, 2'h0, 16'h001e, 1'b0);
      rd(8'h8d, 2'h3, 16'h0019, 1'b0);
      rd(8'hdf, 2'h3, 16'h0019, 1'b0);
      cv(telem_pkg::Q_TEXT, 2'h3, 16'h0000, 16'h0000, 1'b0);
      rd(8'h8d, 2'h3, 16'h001e, 1'b0);
      rd(8'hdf, 2'h3, 16'h001e, 1'b0);
      clear_page = 2'h3;
      clear_faults = 1'b1;
      @(negedge sys_clk);
      clear_faults = 1'b0;
      rd(8'hdf, 2'h3, 16'h7c00, 1'b0);
      rd(8'hfd, 2'h3, 16'h7bff, 1'b0);
      rd(8'hde, 2'h0, 16'h7c00, 1'b0);
      rd(8'hfc, 2'h0, 16'h7bff, 1'b0);
      rd(8'hdd, 2'h1, 16'h1000, 1'b0);
      chan_on = 4'h2;
      rd(8'hdd, 2'h1, 16'hf800, 1'b0);
      rd(8'hfb, 2'h1, 16'hffff, 1'b0);
      rd(8'h01, 2'h0, 16'h0000, 1'b1);
      `CHK(busy_flag_set, 1'b0)
      busy = 1'b1;
      rd(8'hef, 2'h0, 16'h00bd, 1'b0);
      rd(8'h8c, 2'h2, 16'h0000, 1'b1);
      `CHK(busy_flag_set, 1'b1)
      `CHK(alert_oe, 1'b1)
      `CHK(alert_out, 1'b0)
      repeat (4) @(negedge sys_clk);
      rd(8'hef, 2'h0, 16'h003d, 1'b0);
      alert_clear = 1'b1;
      busy = 1'b0;
      share_run = 1'b0;
      wp_in = 1'b0;
      @(negedge sys_clk);
      alert_clear = 1'b0;
      repeat (250) @(negedge sys_clk);
      `CHK(alert_oe, 1'b0)
      rd(8'hef, 2'h0, 16'h00fe, 1'b0);
      final_report();
   end
endmodule
`default_nettype wire
